// File: pkg/timer_share_pkg.sv
// Package for the shared timer start, lockstep and mode control block
package timer_share_pkg;
   localparam logic [7:0] ADDR_RUN = 8'h00;
   localparam logic [7:0] ADDR_SYNC = 8'h04;
   localparam logic [7:0] ADDR_MODE = 8'h08;
   localparam logic [7:0] ADDR_STAT = 8'h0C;
   localparam logic [7:0] ADDR_MASK = 8'h10;
   localparam logic [7:0] ADDR_CMB = 8'h14;
   localparam logic [7:0] ADDR_CNT2 = 8'h18;
   localparam logic [7:0] RESET_RUN = 8'hE0;
   localparam logic [7:0] RESET_SYNC = 8'hE0;
   localparam logic [7:0] RESET_MODE = 8'h80;
   localparam logic [7:0] RO_RUN = 8'hE0;
   localparam logic [7:0] RO_SYNC = 8'hE0;
   localparam logic [7:0] RO_MODE = 8'h80;
   localparam int BIT_PHASE = 6;
   localparam int BIT_FLAG_DIRECTION_SELECT = 5;
   localparam int BIT_PULSE_WIDTH_SEL_CH4 = 4;
   localparam int BIT_PULSE_WIDTH_SEL_CH3 = 3;
   localparam int STAT_OVF = 0;
   localparam int STAT_UNF = 1;
   localparam int STAT_FLAG = 2;
   localparam logic [1:0] CMB_COMPL = 2'h2;
   localparam logic [1:0] CMB_RSYNC = 2'h3;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;

   typedef struct packed {
      logic [4:0] run;
      logic [4:0] lockstep;
      logic [4:0] pwm;
      logic phase;
      logic flag_direction_select;
   } ctrl_type;

   typedef struct packed {
      logic [1:0] ext_a;
      logic [1:0] ext_b;
      logic a_prev;
      logic b_prev;
   } quad_type;

   typedef struct packed {
      logic up;
      logic down;
      logic ovf_set;
   } ch2_evt_type;
endpackage

// File: hw/timer_share_ctrl.sv
// Shared run, lockstep and mode control for a five channel timer
//
// Operation
// R01 - Run register bits 0-4 start channels
// R02 - Run register defaults on reset and standby
// R03 - Run and lockstep top bits read one
// R04 - Lockstep bits gang channel preset and clear
// R05 - Lockstep register defaults on reset, standby
// R06 - Mode register defaults; bit 7 reads one
// R07 - Phase select makes channel 2 quadrature
// R08 - Count each edge of either input
// R09 - A leading B counts up
// R10 - Phase mode overrides clock edge, prescaler
// R11 - Clear, compare, capture, interrupts stay active
// R12 - Flag direction picks overflow flag condition
// R13 - PWM select on channels 4,3 drives output
// R14 - Combination mode overrides channel 4,3 PWM
// R15 - Mode bit 2 selects channel 2 PWM
// R16 - Channels 2,1,0 PWM on compare matches
// R17 - Software halts counters before combination mode
// R18 - Writes to reserved bits are ignored
//
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module timer_share_ctrl
(
   input wire logic i_sys_clk, // System clock, 100 MHz
   input wire logic i_rst, // Async reset, active high
   input wire logic i_standby, // Standby mode entry level
   input wire logic i_hsel, // AHB select
   input wire logic [7:0] i_haddr, // AHB address, low byte
   input wire logic [1:0] i_htrans, // AHB transfer type
   input wire logic i_hwrite, // AHB write
   input wire logic [2:0] i_hsize, // AHB size
   input wire logic [31:0] i_hwdata, // AHB write data
   input wire logic i_hready, // AHB bus ready
   input wire logic i_ext_clock_in_a, // Encoder pin A
   input wire logic i_ext_clock_in_b, // Encoder pin B
   input wire logic [4:0] i_match_a, // Compare match A per channel
   input wire logic [4:0] i_match_b, // Compare match B per channel
   input wire logic i_ch2_wrap_up, // Counter 2 wraps up past max
   input wire logic i_ch2_wrap_down, // Counter 2 wraps down past zero
   output logic [31:0] o_hrdata, // AHB read data
   output logic o_hreadyout, // AHB ready out
   output logic o_hresp, // AHB response, always OKAY
   output logic [4:0] o_run, // Counter run per channel
   output logic [4:0] o_lockstep, // Lockstep preset/clear per channel
   output logic [4:0] o_pwm_active, // Effective PWM mode per channel
   output logic [4:0] o_channel_output_a, // PWM pin level per channel
   output logic o_phase_mode, // Channel 2 in phase counting
   output logic o_ch2_count_up, // Quadrature up step pulse
   output logic o_ch2_count_down, // Quadrature down step pulse
   output logic o_overflow_flag_set, // Channel 2 overflow flag set pulse
   output logic o_irq // Interrupt level
);
   import timer_share_pkg::*;

   typedef struct packed {
      ctrl_type ctrl;
      quad_type quad;
      logic [1:0] cmb;
      logic [2:0] stat;
      logic [2:0] mask;
      logic [15:0] cnt2;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      logic [4:0] pwm_out;
      logic [4:0] pwm_act;
      ch2_evt_type evt;
      logic irq;
   } state_type;

   state_type state;
   state_type next_state;

   logic a_now;
   logic b_now;
   logic [3:0] quad_pair;
   logic step_up;
   logic step_down;
   logic rd_req;
   logic [7:0] run_rd;
   logic [7:0] sync_rd;
   logic [7:0] mode_rd;
   wire logic [4:0] pwm_eff;
   wire logic [4:0] pwm_next;
   wire logic cmb_override;
   logic [2:0] stat_set;
   logic ovf_evt;

   always_comb begin
      next_state = state;
      a_now = state.quad.ext_a[1];
      b_now = state.quad.ext_b[1];
      // Second stage only; first stage feeds nothing else
      next_state.quad.ext_a = {state.quad.ext_a[0], i_ext_clock_in_a};
      next_state.quad.ext_b = {state.quad.ext_b[0], i_ext_clock_in_b};
      next_state.quad.a_prev = a_now;
      next_state.quad.b_prev = b_now;
      quad_pair = {state.quad.a_prev, state.quad.b_prev, a_now, b_now};
      step_up = 1'b0;
      step_down = 1'b0;
      // Gray transition table; a double edge skips a position and is dropped
      if (state.ctrl.phase && state.ctrl.run[2]) begin // R07 R10
         case (quad_pair)
            4'b0010: step_up = 1'b1; // R08 R09
            4'b1011: step_up = 1'b1; // R08 R09
            4'b1101: step_up = 1'b1; // R08 R09
            4'b0100: step_up = 1'b1; // R08 R09
            4'b0001: step_down = 1'b1; // R08 R09
            4'b0111: step_down = 1'b1; // R08 R09
            4'b1110: step_down = 1'b1; // R08 R09
            4'b1000: step_down = 1'b1; // R08 R09
            default: step_up = 1'b0;
         endcase
      end
      next_state.evt.up = step_up;
      next_state.evt.down = step_down;
      // Local channel 2 count view for software reads and the step wrap flags
      if (step_up) begin
         next_state.cnt2 = state.cnt2 + 16'h0001;
      end else if (step_down) begin
         next_state.cnt2 = state.cnt2 - 16'h0001;
      end
      // Overflow flag condition holds in every channel 2 mode
      ovf_evt = (i_ch2_wrap_up || (step_up && state.cnt2 == CNT_MAX))
         || (!state.ctrl.flag_direction_select && (i_ch2_wrap_down || (step_down && state.cnt2 == 16'h0000))); // R12
      next_state.evt.ovf_set = ovf_evt; // R11 R12
      stat_set = '0;
      stat_set[STAT_OVF] = i_ch2_wrap_up || (step_up && state.cnt2 == CNT_MAX);
      stat_set[STAT_UNF] = i_ch2_wrap_down || (step_down && state.cnt2 == 16'h0000);
      stat_set[STAT_FLAG] = ovf_evt;

      // Effective mode and pin levels come from the per channel loop below
      next_state.pwm_act = pwm_eff;
      next_state.pwm_out = pwm_next;

      // Write data phase; set wins over clear for status
      next_state.stat = state.stat | stat_set;
      next_state.wr_pend = 1'b0;
      if (state.wr_pend) begin
         case (state.wr_addr)
            ADDR_RUN: begin
               next_state.ctrl.run = i_hwdata[4:0]; // R01 R18
            end
            ADDR_SYNC: begin
               next_state.ctrl.lockstep = i_hwdata[4:0]; // R04 R18
            end
            ADDR_MODE: begin
               next_state.ctrl.phase = i_hwdata[BIT_PHASE]; // R07 R18
               next_state.ctrl.flag_direction_select = i_hwdata[BIT_FLAG_DIRECTION_SELECT];
               next_state.ctrl.pwm = i_hwdata[4:0];
            end
            ADDR_STAT: begin
               next_state.stat = (state.stat & ~i_hwdata[2:0]) | stat_set;
            end
            ADDR_MASK: begin
               next_state.mask = i_hwdata[2:0];
            end
            ADDR_CMB: begin
               next_state.cmb = i_hwdata[1:0];
            end
            default: begin
               next_state.cmb = state.cmb;
            end
         endcase
      end

      // A read right behind a write sees the written value
      run_rd = {3'h7, next_state.ctrl.run} | RO_RUN; // R03
      sync_rd = {3'h7, next_state.ctrl.lockstep} | RO_SYNC; // R03
      mode_rd = {1'b1, next_state.ctrl.phase, next_state.ctrl.flag_direction_select, next_state.ctrl.pwm} | RO_MODE; // R06

      // Address phase capture; reads answer in the data phase
      rd_req = i_hsel && i_hready && i_htrans[1] && !i_hwrite;
      if (i_hsel && i_hready && i_htrans[1] && i_hwrite) begin
         next_state.wr_pend = 1'b1;
         next_state.wr_addr = i_haddr;
      end
      if (rd_req) begin
         case (i_haddr)
            ADDR_RUN: next_state.rdata = {24'h000000, run_rd};
            ADDR_SYNC: next_state.rdata = {24'h000000, sync_rd};
            ADDR_MODE: next_state.rdata = {24'h000000, mode_rd};
            ADDR_STAT: next_state.rdata = {29'h00000000, next_state.stat};
            ADDR_MASK: next_state.rdata = {29'h00000000, next_state.mask};
            ADDR_CMB: next_state.rdata = {30'h00000000, next_state.cmb};
            ADDR_CNT2: next_state.rdata = {16'h0000, next_state.cnt2};
            default: next_state.rdata = 32'h00000000;
         endcase
      end

      next_state.irq = |(next_state.stat & next_state.mask);

      // Standby returns all three control registers to defaults
      if (i_standby) begin
         next_state.ctrl.run = RESET_RUN[4:0]; // R02
         next_state.ctrl.lockstep = RESET_SYNC[4:0]; // R05
         next_state.ctrl.phase = RESET_MODE[BIT_PHASE]; // R06
         next_state.ctrl.flag_direction_select = RESET_MODE[BIT_FLAG_DIRECTION_SELECT]; // R06
         next_state.ctrl.pwm = RESET_MODE[4:0]; // R06
      end
   end

   // Combination mode wins over per channel PWM on 4 and 3
   assign cmb_override = (state.cmb == CMB_COMPL) || (state.cmb == CMB_RSYNC); // R14
   generate
      for (genvar ch = 0; ch < 5; ch++) begin : g_pwm
         if (ch == BIT_PULSE_WIDTH_SEL_CH4 || ch == BIT_PULSE_WIDTH_SEL_CH3) begin : g_shared
            assign pwm_eff[ch] = state.ctrl.pwm[ch] && !cmb_override; // R13 R14
         end else begin : g_own
            assign pwm_eff[ch] = state.ctrl.pwm[ch]; // R15 R16
         end
         // Match A wins when both compares hit in one cycle
         assign pwm_next[ch] = !pwm_eff[ch] ? 1'b0 :
            i_match_a[ch] ? 1'b1 :
            i_match_b[ch] ? 1'b0 : state.pwm_out[ch]; // R13 R16
      end
   endgenerate

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= '0;
         state.ctrl.run <= RESET_RUN[4:0]; // R02
         state.ctrl.lockstep <= RESET_SYNC[4:0]; // R05
         state.ctrl.phase <= RESET_MODE[BIT_PHASE]; // R06
         state.ctrl.flag_direction_select <= RESET_MODE[BIT_FLAG_DIRECTION_SELECT]; // R06
         state.ctrl.pwm <= RESET_MODE[4:0]; // R06
      end else begin
         state <= next_state;
      end
   end

   // Counters gated by run bits; halting before combination mode is software's job
   assign o_run = state.ctrl.run; // R01
   assign o_lockstep = state.ctrl.lockstep; // R04
   assign o_pwm_active = state.pwm_act;
   assign o_channel_output_a = state.pwm_out;
   assign o_phase_mode = state.ctrl.phase;
   assign o_ch2_count_up = state.evt.up;
   assign o_ch2_count_down = state.evt.down;
   assign o_overflow_flag_set = state.evt.ovf_set;
   assign o_irq = state.irq;
   assign o_hrdata = state.rdata;
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;
endmodule

// File: verification/timer_share_ctrl_props.sv
// Port checker of the shared timer control block
`timescale 1ns/1ps
module timer_share_ctrl_props (
   input wire logic i_sys_clk, // Clock
   input wire logic i_rst, // Reset
   input wire logic i_standby, // Standby
   input wire logic i_ext_clock_in_a, // Pin A
   input wire logic i_ext_clock_in_b, // Pin B
   input wire logic [4:0] i_match_a, // Match A
   input wire logic [4:0] i_match_b, // Match B
   input wire logic i_ch2_wrap_up, // Up wrap
   input wire logic i_ch2_wrap_down, // Down wrap
   input wire logic [4:0] o_run, // Run
   input wire logic [4:0] o_lockstep, // Lockstep
   input wire logic [4:0] o_pwm_active, // PWM
   input wire logic [4:0] o_channel_output_a, // PWM pins
   input wire logic o_phase_mode, // Phase
   input wire logic o_ch2_count_up, // Up step
   input wire logic o_ch2_count_down, // Down step
   input wire logic o_overflow_flag_set // Flag set
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   a_standby_defaults: assert property (i_standby |=> !o_run && !o_lockstep && !o_phase_mode)
      else $error("standby left control bits set");
   a_pwm_match_a: assert property (o_pwm_active[1] && i_match_a[1] ##1 o_pwm_active[1] |-> o_channel_output_a[1])
      else $error("match A did not raise pin");
   a_pwm_match_b: assert property (o_pwm_active[1] && i_match_b[1] && !i_match_a[1] ##1 o_pwm_active[1]
      |-> !o_channel_output_a[1])
      else $error("match B did not lower pin");
   // Three idle cycles cover the registered mode lag
   a_pwm_off_low: assert property (!o_pwm_active[4] [*3] |-> !o_channel_output_a[4])
      else $error("pin driven outside PWM mode");
   a_ovf_on_up: assert property (i_ch2_wrap_up |=> o_overflow_flag_set)
      else $error("overflow flag not set on up wrap");
   a_ovf_needs_wrap: assert property (!$past(i_ch2_wrap_up) && !$past(i_ch2_wrap_down)
      && !o_ch2_count_up && !o_ch2_count_down |-> !o_overflow_flag_set)
      else $error("overflow flag set with no wrap");
   a_step_in_mode: assert property (o_ch2_count_up || o_ch2_count_down
      |-> $past(o_phase_mode) && $past(o_run[2]))
      else $error("step outside phase counting");
   a_pins_idle: assert property ($stable({i_ext_clock_in_a, i_ext_clock_in_b}) [*6]
      |-> !o_ch2_count_up && !o_ch2_count_down)
      else $error("step without pin edge");
endmodule
bind timer_share_ctrl timer_share_ctrl_props props (.i_sys_clk, .i_rst, .i_standby, .i_ext_clock_in_a,
   .i_ext_clock_in_b, .i_match_a, .i_match_b, .i_ch2_wrap_up, .i_ch2_wrap_down, .o_run, .o_lockstep,
   .o_pwm_active, .o_channel_output_a, .o_phase_mode, .o_ch2_count_up, .o_ch2_count_down,
   .o_overflow_flag_set);

// File: verification/quad_enc_model.sv
// Quadrature encoder model driving the two clock pins
`timescale 1ns/1ps
module quad_enc_model (
   input wire logic i_sys_clk, // Clock
   input wire logic i_up, // Step forward
   input wire logic i_dn, // Step back
   output logic o_a, // Pin A
   output logic o_b // Pin B
);
   logic [1:0] pos = 2'h0;
   always @(posedge i_sys_clk) begin
      pos <= pos + 2'(i_up) - 2'(i_dn);
   end
   // Gray order moves one pin per step; forward has A leading B
   assign o_a = pos[0] ^ pos[1];
   assign o_b = pos[1];
endmodule

// File: verification/timer_share_ctrl_test.sv
// Self-checking bench of the shared timer control block
`timescale 1ns/1ps
module timer_share_ctrl_test;
   import timer_share_pkg::*;
   logic i_sys_clk = 1'b0, i_rst = 1'b1, i_standby = 1'b0, i_hsel = 1'b0, i_hwrite = 1'b0;
   logic i_ch2_wrap_up = 1'b0, i_ch2_wrap_down = 1'b0, step_up = 1'b0, step_dn = 1'b0;
   logic [7:0] i_haddr = 8'h00;
   logic [1:0] i_htrans = 2'h0;
   logic [31:0] i_hwdata = 32'h0, o_hrdata, q;
   logic [4:0] i_match_a = 5'h00, i_match_b = 5'h00, o_run, o_lockstep, o_pwm_active, o_channel_output_a;
   logic i_ext_clock_in_a, i_ext_clock_in_b, o_hreadyout, o_hresp, o_phase_mode, o_irq;
   logic o_ch2_count_up, o_ch2_count_down, o_overflow_flag_set;
   int miscompares = 0, checks = 0, cyc = 0, ups = 0, dns = 0, ovfs = 0;
   always #5 i_sys_clk = ~i_sys_clk;
   timer_share_ctrl DUT (.i_sys_clk, .i_rst, .i_standby, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
      .i_hsize(3'h2), .i_hwdata, .i_hready(o_hreadyout), .i_ext_clock_in_a, .i_ext_clock_in_b,
      .i_match_a, .i_match_b, .i_ch2_wrap_up, .i_ch2_wrap_down, .o_hrdata, .o_hreadyout, .o_hresp,
      .o_run, .o_lockstep, .o_pwm_active, .o_channel_output_a, .o_phase_mode, .o_ch2_count_up,
      .o_ch2_count_down, .o_overflow_flag_set, .o_irq);
   quad_enc_model ENC (.i_sys_clk, .i_up(step_up), .i_dn(step_dn), .o_a(i_ext_clock_in_a),
      .o_b(i_ext_clock_in_b));
   task automatic complete_run;
      if (miscompares == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge i_sys_clk) begin
      cyc++;
      ups += int'(o_ch2_count_up === 1'b1);
      dns += int'(o_ch2_count_down === 1'b1);
      ovfs += int'(o_overflow_flag_set === 1'b1);
      if (cyc == 5000) begin
         miscompares++;
         complete_run;
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Address phase held until ready, then data phase until ready again
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      i_haddr <= a;
      i_hwrite <= w;
      i_htrans <= 2'h2;
      i_hsel <= 1'b1;
      do tick(1); while (o_hreadyout !== 1'b1);
      i_htrans <= 2'h0;
      i_hwdata <= d;
      do tick(1); while (o_hreadyout !== 1'b1);
      q = o_hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0);
      chk(q, e);
   endtask
   task automatic step(input logic up);
      step_up <= up;
      step_dn <= !up;
      tick(1);
      step_up <= 1'b0;
      step_dn <= 1'b0;
      tick(8);
   endtask
   task automatic wrap(input logic up);
      i_ch2_wrap_up <= up;
      i_ch2_wrap_down <= !up;
      tick(1);
      i_ch2_wrap_up <= 1'b0;
      i_ch2_wrap_down <= 1'b0;
      tick(2);
   endtask
   initial begin
      tick(10);
      i_rst <= 1'b0;
      tick(1);
      rd(ADDR_RUN, 32'hE0);
      rd(ADDR_SYNC, 32'hE0);
      rd(ADDR_MODE, 32'h80);
      rd(8'h1C, 32'h0);
      chk(32'(o_hresp), 32'h0);
      bus(ADDR_RUN, 1'b1, 32'hFF);
      rd(ADDR_RUN, 32'hFF);
      chk(32'(o_run), 32'h1F);
      bus(ADDR_SYNC, 1'b1, 32'h15);
      rd(ADDR_SYNC, 32'hF5);
      chk(32'(o_lockstep), 32'h15);
      bus(ADDR_MODE, 1'b1, 32'h1F);
      rd(ADDR_MODE, 32'h9F);
      i_match_a <= 5'h1F;
      tick(1);
      i_match_a <= 5'h00;
      tick(2);
      chk(32'(o_channel_output_a), 32'h1F);
      i_match_b <= 5'h1F;
      tick(1);
      i_match_b <= 5'h00;
      tick(2);
      chk(32'(o_channel_output_a), 32'h0);
      bus(ADDR_RUN, 1'b1, 32'h00);
      tick(1);
      chk(32'(o_run), 32'h00);
      for (int m = 0; m < 4; m++) begin
         bus(ADDR_CMB, 1'b1, 32'(m));
         tick(2);
         chk(32'(o_pwm_active), m > 1 ? 32'h07 : 32'h1F);
      end
      i_match_a <= 5'h1F;
      tick(1);
      i_match_a <= 5'h00;
      tick(2);
      chk(32'(o_channel_output_a), 32'h07);
      bus(ADDR_CMB, 1'b1, 32'h0);
      bus(ADDR_RUN, 1'b1, 32'h1F);
      bus(ADDR_MODE, 1'b1, 32'h40);
      tick(2);
      chk(32'(o_phase_mode), 32'h1);
      repeat (4) step(1'b1);
      chk(ups, 4);
      repeat (3) step(1'b0);
      chk(dns, 3);
      wrap(1'b0);
      chk(ovfs, 1);
      rd(ADDR_STAT, 32'h6);
      chk(32'(o_irq), 32'h0);
      bus(ADDR_MASK, 1'b1, 32'h4);
      tick(2);
      chk(32'(o_irq), 32'h1);
      bus(ADDR_STAT, 1'b1, 32'h6);
      tick(2);
      chk(32'(o_irq), 32'h0);
      bus(ADDR_MODE, 1'b1, 32'h60);
      wrap(1'b0);
      wrap(1'b1);
      chk(ovfs, 2);
      i_standby <= 1'b1;
      tick(1);
      i_standby <= 1'b0;
      tick(1);
      rd(ADDR_RUN, 32'hE0);
      rd(ADDR_SYNC, 32'hE0);
      rd(ADDR_MODE, 32'h80);
      complete_run;
   end
endmodule
